// [rtl/fspu_defs.svh]
// constants of the flash sector protection unit
// assumes word addressing with 64k-word large sectors
`ifndef FSPU_DEFS_SVH
`define FSPU_DEFS_SVH

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define FSPU_AW            26
`define FSPU_SEC_HI        25
`define FSPU_SEC_LO        16
`define FSPU_SUB_HI        15
`define FSPU_SUB_LO        14
`define FSPU_OFS_HI        15
`define FSPU_RV_BIT        6
`define FSPU_SMALL_HI      3
`define FSPU_SMALL_SEC     10'h3ff
`define FSPU_LOW_SEC       10'h000
`define FSPU_HWP_SUB_MAX   2'h1

// ----------------------------------------------------------------
// unlock cycle offsets inside a sector
// ----------------------------------------------------------------
`define FSPU_UNLOCK_CYCLE_ADDR_FIRST_OFS      16'h0555
`define FSPU_UNLOCK_CYCLE_ADDR_SECOND_OFS      16'h0aaa

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FSPU_CMD_LOCK      16'h0060
`define FSPU_CMD_LDADDR    16'h0061
`define FSPU_CMD_BUFLOAD   16'h0025
`define FSPU_CMD_CONFIRM   16'h0029
`define FSPU_CMD_EXIT      16'h00f0
`define FSPU_CMD_ENTRY     16'h0088

// ----------------------------------------------------------------
// write buffer
// ----------------------------------------------------------------
`define FSPU_WC_W          8
`define FSPU_WC_ZERO       8'h00
`define FSPU_WC_ONE        8'h01

`endif

// [rtl/fspu_pkg.sv]
// types of the flash sector protection unit
// assumes fspu_defs.svh for widths
`include "fspu_defs.svh"

package fspu_pkg;

    typedef enum logic [5:0] {
        FSPU_IDLE = 6'h01,
        FSPU_SET1 = 6'h02,
        FSPU_SET2 = 6'h04,
        FSPU_RLO  = 6'h08,
        FSPU_BCNT = 6'h10,
        FSPU_BDAT = 6'h20
    } fspu_state_t;

    typedef struct packed {
        fspu_state_t            st;
        logic                   por_mode;
        logic                   slr_done;
        logic                   slr_large;
        logic [9:0]             lo_sec;
        logic [9:0]             hi_sec;
        logic [3:0]             small_lock;
        logic                   unl_valid;
        logic [9:0]             unl_sec;
        logic [1:0]             unl_sub;
        logic [9:0]             tmp_lo;
        logic                   tmp_rv;
        logic [3:0]             tmp_small;
        logic                   overlay;
        logic [`FSPU_WC_W-1:0]  wc;
        logic [`FSPU_WC_W-1:0]  left;
        logic                   buf_full;
        logic                   grant;
        logic                   reject;
        logic                   prog_start;
        logic                   prog_fail;
    } fspu_reg_t;

endpackage

// [rtl/fspu_top.sv]
// sector protection logic and command decoder of a parallel nor flash
// assumes host write cycles arrive one per i_wr_valid pulse, in sync
// with i_sys_clk; the embedded algorithm asks for leave to start
`timescale 1ns/100ps
`include "fspu_defs.svh"

module fspu_top
    import fspu_pkg::*;
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_top_boot_model,
    input  wire logic                  i_hw_protect_input,
    input  wire logic                  i_wr_valid,
    input  wire logic [`FSPU_AW-1:0]   i_wr_addr,
    input  wire logic [15:0]           i_wr_data,
    input  wire logic                  i_op_start,
    input  wire logic                  i_op_resume,
    input  wire logic                  i_op_secure,
    input  wire logic [`FSPU_AW-1:0]   i_op_addr,
    input  wire logic                  i_otp_customer_locked,
    output logic                       o_op_grant,
    output logic                       o_op_reject,
    output logic                       o_por_unlocked,
    output logic                       o_range_accepted,
    output logic                       o_unlock_valid,
    output logic [9:0]                 o_unlock_sector,
    output logic                       o_overlay_active,
    output logic                       o_otp_prog_start,
    output logic                       o_otp_prog_fail,
    output logic [`FSPU_WC_W-1:0]      o_otp_word_count
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fspu_reg_t r;
    fspu_reg_t next_r;

    logic [9:0]  wr_sec;
    logic [15:0] wr_ofs;
    logic        wr_rv;
    logic        at_unlock_cycle_addr_first;
    logic        at_unlock_cycle_addr_second;
    logic [9:0]  op_sec;
    logic [1:0]  op_sub;
    logic        op_small;
    logic        hw_guard;
    logic        in_range;
    logic        small_hit;
    logic        range_lock;
    logic        unl_hit;
    logic        op_free;
    logic        wr_small;
    logic        wr_in_range;
    logic        rng_ok;
    logic        rng_large;

    assign wr_sec  = i_wr_addr[`FSPU_SEC_HI:`FSPU_SEC_LO];
    assign wr_ofs  = i_wr_addr[`FSPU_OFS_HI:0];
    assign wr_rv   = i_wr_addr[`FSPU_RV_BIT];
    assign at_unlock_cycle_addr_first = (wr_ofs == `FSPU_UNLOCK_CYCLE_ADDR_FIRST_OFS);
    assign at_unlock_cycle_addr_second = (wr_ofs == `FSPU_UNLOCK_CYCLE_ADDR_SECOND_OFS);
    assign op_sec  = i_op_addr[`FSPU_SEC_HI:`FSPU_SEC_LO];
    assign op_sub  = i_op_addr[`FSPU_SUB_HI:`FSPU_SUB_LO];
    assign op_small = i_top_boot_model && (op_sec == `FSPU_SMALL_SEC);

    // ----------------------------------------------------------------
    // protection decision for an operation target
    // ----------------------------------------------------------------
    // hardware protect input, only when low
    always_comb begin
        if (i_hw_protect_input) begin
            hw_guard = 1'b0;
        end else if (i_top_boot_model) begin
            hw_guard = op_small && (op_sub <= `FSPU_HWP_SUB_MAX);
        end else begin
            hw_guard = (op_sec == `FSPU_LOW_SEC);
        end
    end

    // range covers the sector
    assign in_range = r.slr_done && r.slr_large &&
                      (op_sec >= r.lo_sec) && (op_sec <= r.hi_sec);

    // small sector bits; bit 0 guards the highest small sector
    assign small_hit = r.slr_done && op_small &&
                       r.small_lock[`FSPU_SMALL_HI - op_sub];

    assign range_lock = in_range || small_hit;

    // the one unlocked sector; range wins over it
    assign unl_hit = r.unl_valid && (r.unl_sec == op_sec) &&
                     (!op_small || (r.unl_sub == op_sub)) && !range_lock;

    // guard beats power-on unlocked mode
    assign op_free = !hw_guard && (r.por_mode || unl_hit);

    // ----------------------------------------------------------------
    // checks on the write being decoded
    // ----------------------------------------------------------------
    assign wr_small = i_top_boot_model && (wr_sec == `FSPU_SMALL_SEC);
    assign wr_in_range = r.slr_done && (
        (r.slr_large && (wr_sec >= r.lo_sec) && (wr_sec <= r.hi_sec)) ||
        (wr_small &&
         r.small_lock[`FSPU_SMALL_HI -
                      i_wr_addr[`FSPU_SUB_HI:`FSPU_SUB_LO]]));

    // range valid bits must match; low not above high unless both bits are high
    assign rng_large = !r.tmp_rv;
    assign rng_ok = (r.tmp_rv == wr_rv) &&
                    (wr_rv || (r.tmp_lo <= wr_sec));

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.grant      = 1'b0;
        next_r.reject     = 1'b0;
        next_r.prog_start = 1'b0;
        next_r.prog_fail  = 1'b0;

        // operation start is judged once, here
        if (i_op_start) begin
            if (i_op_resume) begin
                next_r.grant = 1'b1;
            end else if (i_op_secure) begin
                // secure region ignores the guard and the sector lock
                next_r.grant  = !i_otp_customer_locked;
                next_r.reject = i_otp_customer_locked;
            end else begin
                next_r.grant  = op_free;
                next_r.reject = !op_free;
            end
        end

        if (i_wr_valid) begin
            unique case (r.st)
                FSPU_IDLE: begin
                    if (i_wr_data == `FSPU_CMD_EXIT) begin
                        next_r.overlay = 1'b0;
                    end else if (at_unlock_cycle_addr_first &&
                                 i_wr_data == `FSPU_CMD_LOCK) begin
                        next_r.st = FSPU_SET1;
                    end else if (at_unlock_cycle_addr_first &&
                                 i_wr_data == `FSPU_CMD_ENTRY) begin
                        next_r.overlay = 1'b1;
                    end else if (r.overlay && at_unlock_cycle_addr_first &&
                                 i_wr_data == `FSPU_CMD_BUFLOAD) begin
                        next_r.st = FSPU_BCNT;
                    end
                end
                FSPU_SET1: begin
                    if (at_unlock_cycle_addr_second && i_wr_data == `FSPU_CMD_LOCK) begin
                        next_r.st = FSPU_SET2;
                    end else begin
                        next_r.st = FSPU_IDLE;
                    end
                end
                FSPU_SET2: begin
                    next_r.st = FSPU_IDLE;
                    if (i_wr_data == `FSPU_CMD_LDADDR) begin
                        // low bound and small bits
                        next_r.tmp_lo    = wr_sec;
                        next_r.tmp_rv    = wr_rv;
                        next_r.tmp_small =
                            i_wr_addr[`FSPU_SMALL_HI:0];
                        next_r.st        = FSPU_RLO;
                    end else if (i_wr_data == `FSPU_CMD_LOCK) begin
                        next_r.por_mode = 1'b0;
                        if (wr_rv && !wr_in_range) begin
                            next_r.unl_valid = 1'b1;
                            next_r.unl_sec   = wr_sec;
                            next_r.unl_sub   =
                                i_wr_addr[`FSPU_SUB_HI:`FSPU_SUB_LO];
                        end else begin
                            // bit low, or target inside the range
                            next_r.unl_valid = 1'b0;
                        end
                    end
                end
                FSPU_RLO: begin
                    next_r.st = FSPU_IDLE;
                    // only the first valid range counts
                    if (i_wr_data == `FSPU_CMD_LDADDR &&
                        rng_ok && !r.slr_done) begin
                        next_r.slr_done  = 1'b1;
                        next_r.slr_large = rng_large;
                        next_r.lo_sec    = r.tmp_lo;
                        next_r.hi_sec    = wr_sec;
                        next_r.por_mode  = 1'b0;
                        // range over the small area locks all four
                        if (i_top_boot_model && rng_large &&
                            wr_sec == `FSPU_SMALL_SEC) begin
                            next_r.small_lock = 4'hf;
                        end else if (i_top_boot_model) begin
                            next_r.small_lock = r.tmp_small;
                        end else begin
                            next_r.small_lock = 4'h0;
                        end
                        // covered unlocked sector falls back
                        if (rng_large && (r.unl_sec >= r.tmp_lo) &&
                            (r.unl_sec <= wr_sec)) begin
                            next_r.unl_valid = 1'b0;
                        end
                    end
                end
                FSPU_BCNT: begin
                    if (at_unlock_cycle_addr_second) begin
                        next_r.wc   = i_wr_data[`FSPU_WC_W-1:0];
                        next_r.left = i_wr_data[`FSPU_WC_W-1:0];
                        next_r.buf_full = 1'b0;
                        next_r.st   = FSPU_BDAT;
                    end else begin
                        next_r.st = FSPU_IDLE;
                    end
                end
                FSPU_BDAT: begin
                    // a separate flag marks the confirm slot, since a
                    // full 256 word count wraps the 8 bit down counter
                    if (!r.buf_full) begin
                        next_r.left = r.left - `FSPU_WC_ONE;
                        if (r.left == `FSPU_WC_ZERO) begin
                            next_r.buf_full = 1'b1;
                        end
                    end else begin
                        next_r.st = FSPU_IDLE;
                        if (at_unlock_cycle_addr_first &&
                            i_wr_data == `FSPU_CMD_CONFIRM) begin
                            next_r.prog_start =
                                !i_otp_customer_locked;
                            next_r.prog_fail  =
                                i_otp_customer_locked;
                        end
                    end
                end
            endcase
            // exit code aborts any pending sequence outside the data phase
            if (r.st != FSPU_BDAT && r.st != FSPU_IDLE &&
                i_wr_data == `FSPU_CMD_EXIT) begin
                next_r.st = FSPU_IDLE;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers; reset is power-up write inhibit and clears all but por_mode, which it sets, and st, which it loads with FSPU_IDLE
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r.st         <= FSPU_IDLE;
            r.por_mode   <= 1'b1;
            r.slr_done   <= 1'b0;
            r.slr_large  <= 1'b0;
            r.lo_sec     <= 10'h000;
            r.hi_sec     <= 10'h000;
            r.small_lock <= 4'h0;
            r.unl_valid  <= 1'b0;
            r.unl_sec    <= 10'h000;
            r.unl_sub    <= 2'h0;
            r.tmp_lo     <= 10'h000;
            r.tmp_rv     <= 1'b0;
            r.tmp_small  <= 4'h0;
            r.overlay    <= 1'b0;
            r.wc         <= `FSPU_WC_ZERO;
            r.left       <= `FSPU_WC_ZERO;
            r.buf_full   <= 1'b0;
            r.grant      <= 1'b0;
            r.reject     <= 1'b0;
            r.prog_start <= 1'b0;
            r.prog_fail  <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_op_grant       = r.grant;
    assign o_op_reject      = r.reject;
    assign o_por_unlocked   = r.por_mode;
    assign o_range_accepted = r.slr_done;
    assign o_unlock_valid   = r.unl_valid;
    assign o_unlock_sector  = r.unl_sec;
    assign o_overlay_active = r.overlay;
    assign o_otp_prog_start = r.prog_start;
    assign o_otp_prog_fail  = r.prog_fail;
    assign o_otp_word_count = r.wc;

endmodule

// [verif/fspu_host.sv]
// host model that issues flash command write cycles
// assumes calls are made just after a rising edge of i_sys_clk
`timescale 1ns/100ps
`include "fspu_defs.svh"

module fspu_host (
    input  wire logic              i_sys_clk,
    output logic                   o_wr_valid,
    output logic [`FSPU_AW-1:0]    o_wr_addr,
    output logic [15:0]            o_wr_data
);
    initial begin
        o_wr_valid = 1'b0;
        o_wr_addr  = 26'h0000000;
        o_wr_data  = 16'h0000;
    end
    // one write per cycle, held until the sampling edge
    task automatic wr(input logic [25:0] a, input logic [15:0] d);
        o_wr_valid = 1'b1;
        o_wr_addr  = a;
        o_wr_data  = d;
        @(posedge i_sys_clk);
        #1;
    endtask
    // a released bus shows the inverse of its last value
    task automatic idle();
        o_wr_valid = 1'b0;
        o_wr_addr  = ~o_wr_addr;
        o_wr_data  = ~o_wr_data;
        @(posedge i_sys_clk);
        #1;
    endtask
    task automatic setup(input logic [9:0] s);
        wr({s, `FSPU_UNLOCK_CYCLE_ADDR_FIRST_OFS}, `FSPU_CMD_LOCK);
        wr({s, `FSPU_UNLOCK_CYCLE_ADDR_SECOND_OFS}, `FSPU_CMD_LOCK);
    endtask
    // rv high unlocks sector s, rv low locks all
    task automatic sect(input logic [9:0] s, input logic [1:0] sb,
                        input logic rv);
        setup(s);
        wr({s, sb, 7'h00, rv, 6'h00}, `FSPU_CMD_LOCK);
        idle();
    endtask
    task automatic range(input logic [9:0] lo, input logic lrv,
                         input logic [3:0] sm, input logic [9:0] hi,
                         input logic hrv);
        setup(lo);
        wr({lo, 9'h000, lrv, 2'h0, sm}, `FSPU_CMD_LDADDR);
        wr({hi, 9'h000, hrv, 6'h00}, `FSPU_CMD_LDADDR);
        idle();
    endtask
    // buffered secure program, ends on the confirm edge
    task automatic otp(input logic [9:0] s, input int n);
        wr({s, `FSPU_UNLOCK_CYCLE_ADDR_FIRST_OFS}, `FSPU_CMD_BUFLOAD);
        wr({s, `FSPU_UNLOCK_CYCLE_ADDR_SECOND_OFS}, 16'(n - 1));
        for (int i = 0; i < n; i++) begin
            wr({s, 16'(i)}, 16'(i + 3));
        end
        wr({s, `FSPU_UNLOCK_CYCLE_ADDR_FIRST_OFS}, `FSPU_CMD_CONFIRM);
    endtask
endmodule

// [verif/fspu_top_sva.sv]
// port assertions for the sector protection unit
// assumes it is bound into fspu_top
`timescale 1ns/100ps
`include "fspu_defs.svh"

module fspu_chk (
    input wire logic                i_sys_clk,
    input wire logic                i_rst_n,
    input wire logic                i_top_boot_model,
    input wire logic                i_hw_protect_input,
    input wire logic                i_wr_valid,
    input wire logic [`FSPU_AW-1:0] i_wr_addr,
    input wire logic [15:0]         i_wr_data,
    input wire logic                i_op_start,
    input wire logic                i_op_resume,
    input wire logic                i_op_secure,
    input wire logic [`FSPU_AW-1:0] i_op_addr,
    input wire logic                i_otp_customer_locked,
    input wire logic                o_op_grant,
    input wire logic                o_op_reject,
    input wire logic                o_por_unlocked,
    input wire logic                o_range_accepted,
    input wire logic                o_unlock_valid
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic arr;
    logic w60;
    assign arr = i_op_start && !i_op_resume && !i_op_secure;
    assign w60 = i_wr_valid && (i_wr_data == `FSPU_CMD_LOCK);
    property p_answer; i_op_start |=> o_op_grant ^ o_op_reject; endproperty
    a_answer: assert property (p_answer)
        else $error("op start without one answer");
    property p_quiet; !i_op_start |=> !o_op_grant && !o_op_reject;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("answer without op start");
    property p_resume; i_op_start && i_op_resume |=> o_op_grant; endproperty
    a_resume: assert property (p_resume)
        else $error("resume refused");
    property p_otp; i_op_start && !i_op_resume && i_op_secure
        && i_otp_customer_locked |=> o_op_reject; endproperty
    a_otp: assert property (p_otp)
        else $error("locked secure program granted");
    property p_sec; i_op_start && !i_op_resume && i_op_secure
        && !i_otp_customer_locked |=> o_op_grant; endproperty
    a_sec: assert property (p_sec)
        else $error("open secure program refused");
    property p_hwp; arr && !i_hw_protect_input && i_top_boot_model
        && i_op_addr[25:16] == `FSPU_SMALL_SEC
        && i_op_addr[15:14] <= `FSPU_HWP_SUB_MAX |=> o_op_reject; endproperty
    a_hwp: assert property (p_hwp)
        else $error("guarded small sector granted");
    property p_once; o_range_accepted |=> o_range_accepted; endproperty
    a_once: assert property (p_once)
        else $error("range acceptance dropped");
    property p_por; !o_por_unlocked |=> !o_por_unlocked; endproperty
    a_por: assert property (p_por)
        else $error("unlocked mode came back");
    property p_lock;
        w60 && i_wr_addr[15:0] == `FSPU_UNLOCK_CYCLE_ADDR_FIRST_OFS
        ##1 w60 && i_wr_addr[15:0] == `FSPU_UNLOCK_CYCLE_ADDR_SECOND_OFS
        ##1 w60 && !i_wr_addr[`FSPU_RV_BIT] |=> !o_unlock_valid;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock all kept an unlocked sector");
endmodule

bind fspu_top fspu_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_top_boot_model(i_top_boot_model),
    .i_hw_protect_input(i_hw_protect_input), .i_wr_valid(i_wr_valid),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .i_op_start(i_op_start), .i_op_resume(i_op_resume),
    .i_op_secure(i_op_secure), .i_op_addr(i_op_addr),
    .i_otp_customer_locked(i_otp_customer_locked),
    .o_op_grant(o_op_grant), .o_op_reject(o_op_reject),
    .o_por_unlocked(o_por_unlocked), .o_range_accepted(o_range_accepted),
    .o_unlock_valid(o_unlock_valid)
);

// [verif/flash_sector_protection_unit_tb.sv]
// self-checking bench for the sector protection unit
// assumes fspu_host drives the write port
`timescale 1ns/100ps
`include "fspu_defs.svh"

module flash_sector_protection_unit_tb;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_top_boot_model = 1'b1;
    logic i_hw_protect_input = 1'b1, i_op_start = 1'b0, i_op_resume = 1'b0;
    logic i_op_secure = 1'b0, i_otp_customer_locked = 1'b0;
    logic [`FSPU_AW-1:0] i_op_addr = 26'h0000000, w_addr;
    logic [15:0] w_data;
    logic w_valid, o_op_grant, o_op_reject, o_por_unlocked, o_unlock_valid;
    logic o_range_accepted, o_overlay_active, o_otp_prog_start;
    logic o_otp_prog_fail;
    logic [9:0] o_unlock_sector;
    logic [`FSPU_WC_W-1:0] o_otp_word_count;
    logic [1:0] p, q;
    int n_errors = 0, checks = 0;

    always #20 i_sys_clk = ~i_sys_clk;
    fspu_host host (.i_sys_clk(i_sys_clk), .o_wr_valid(w_valid),
        .o_wr_addr(w_addr), .o_wr_data(w_data));
    fspu_top dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_top_boot_model(i_top_boot_model),
        .i_hw_protect_input(i_hw_protect_input), .i_wr_valid(w_valid),
        .i_wr_addr(w_addr), .i_wr_data(w_data), .i_op_start(i_op_start),
        .i_op_resume(i_op_resume), .i_op_secure(i_op_secure),
        .i_op_addr(i_op_addr),
        .i_otp_customer_locked(i_otp_customer_locked),
        .o_op_grant(o_op_grant), .o_op_reject(o_op_reject),
        .o_por_unlocked(o_por_unlocked),
        .o_range_accepted(o_range_accepted),
        .o_unlock_valid(o_unlock_valid), .o_unlock_sector(o_unlock_sector),
        .o_overlay_active(o_overlay_active),
        .o_otp_prog_start(o_otp_prog_start),
        .o_otp_prog_fail(o_otp_prog_fail),
        .o_otp_word_count(o_otp_word_count));

    task automatic results();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // op request; answer sampled 1 ns after the taking edge
    task automatic opc(input logic [9:0] s, input logic [1:0] sb,
                       input logic rs, input logic sc, input logic g);
        i_op_start  = 1'b1;
        i_op_addr   = {s, sb, 14'h0000};
        i_op_resume = rs;
        i_op_secure = sc;
        @(posedge i_sys_clk);
        #1;
        i_op_start = 1'b0;
        chk("op answer", {14'h0, g, ~g}, {14'h0, o_op_grant, o_op_reject});
        @(posedge i_sys_clk);
        #1;
    endtask
    task automatic rst();
        i_rst_n = 1'b0;
        host.sect(10'h00a, 2'h0, 1'b1);
        i_rst_n = 1'b1;
    endtask

    task automatic t_por();
        rst();
        chk("unlock during reset", 16'h0, 16'(o_unlock_valid));
        chk("por mode", 16'h1, 16'(o_por_unlocked));
        chk("range", 16'h0, 16'(o_range_accepted));
        chk("overlay", 16'h0, 16'(o_overlay_active));
        opc(10'h005, 2'h0, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_hwp();
        i_hw_protect_input = 1'b0;
        opc(10'h3ff, 2'h0, 1'b0, 1'b0, 1'b0);
        opc(10'h3ff, 2'h1, 1'b0, 1'b0, 1'b0);
        opc(10'h3ff, 2'h2, 1'b0, 1'b0, 1'b1);
        opc(10'h3ff, 2'h0, 1'b0, 1'b1, 1'b1);
        i_top_boot_model = 1'b0;
        opc(10'h000, 2'h0, 1'b0, 1'b0, 1'b0);
        opc(10'h001, 2'h0, 1'b0, 1'b0, 1'b1);
        i_hw_protect_input = 1'b1;
        opc(10'h000, 2'h0, 1'b0, 1'b0, 1'b1);
        i_top_boot_model = 1'b1;
    endtask
    task automatic t_unlock();
        host.sect(10'h00a, 2'h0, 1'b1);
        chk("por mode", 16'h0, 16'(o_por_unlocked));
        chk("unlock sector", 16'h040a,
            {5'h0, o_unlock_valid, o_unlock_sector});
        opc(10'h00a, 2'h0, 1'b0, 1'b0, 1'b1);
        opc(10'h00b, 2'h0, 1'b0, 1'b0, 1'b0);
        host.sect(10'h00b, 2'h0, 1'b1);
        opc(10'h00a, 2'h0, 1'b0, 1'b0, 1'b0);
        host.sect(10'h003, 2'h0, 1'b0);
        chk("unlock valid", 16'h0, 16'(o_unlock_valid));
        opc(10'h00b, 2'h0, 1'b0, 1'b0, 1'b0);
        opc(10'h00b, 2'h0, 1'b1, 1'b0, 1'b1);
    endtask
    task automatic t_range();
        rst();
        host.range(10'h009, 1'b0, 4'h0, 10'h005, 1'b0);
        chk("range", 16'h0, 16'(o_range_accepted));
        host.range(10'h005, 1'b0, 4'h0, 10'h008, 1'b1);
        chk("range", 16'h0, 16'(o_range_accepted));
        host.sect(10'h008, 2'h0, 1'b1);
        host.range(10'h005, 1'b0, 4'h1, 10'h008, 1'b0);
        chk("range", 16'h1, 16'(o_range_accepted));
        chk("unlock valid", 16'h0, 16'(o_unlock_valid));
        opc(10'h008, 2'h0, 1'b0, 1'b0, 1'b0);
        host.sect(10'h009, 2'h0, 1'b1);
        opc(10'h009, 2'h0, 1'b0, 1'b0, 1'b1);
        host.sect(10'h005, 2'h0, 1'b1);
        opc(10'h005, 2'h0, 1'b0, 1'b0, 1'b0);
        opc(10'h009, 2'h0, 1'b0, 1'b0, 1'b0);
        host.sect(10'h3ff, 2'h3, 1'b1);
        opc(10'h3ff, 2'h3, 1'b0, 1'b0, 1'b0);
        host.sect(10'h3ff, 2'h2, 1'b1);
        opc(10'h3ff, 2'h2, 1'b0, 1'b0, 1'b1);
        host.range(10'h000, 1'b0, 4'h0, 10'h014, 1'b0);
        host.sect(10'h00c, 2'h0, 1'b1);
        opc(10'h00c, 2'h0, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_both();
        rst();
        host.range(10'h006, 1'b1, 4'h0, 10'h009, 1'b1);
        chk("por mode", 16'h0, 16'(o_por_unlocked));
        host.sect(10'h007, 2'h0, 1'b1);
        opc(10'h007, 2'h0, 1'b0, 1'b0, 1'b1);
        rst();
        host.range(10'h3fe, 1'b0, 4'h0, 10'h3ff, 1'b0);
        host.sect(10'h3ff, 2'h2, 1'b1);
        opc(10'h3ff, 2'h2, 1'b0, 1'b0, 1'b0);
        rst();
        host.range(10'h006, 1'b0, 4'h0, 10'h006, 1'b0);
        host.sect(10'h007, 2'h0, 1'b1);
        opc(10'h007, 2'h0, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_otp(input int n, input logic lk);
        i_otp_customer_locked = lk;
        host.otp(10'h002, n);
        p = {o_otp_prog_start, o_otp_prog_fail};
        host.idle();
        q = {o_otp_prog_start, o_otp_prog_fail};
        chk("otp pulse", {14'h0, ~lk, lk}, {14'h0, p | q});
        chk("otp once", 16'h0, {14'h0, p & q});
        chk("word count", 16'(n - 1), {8'h0, o_otp_word_count});
        opc(10'h002, 2'h0, 1'b0, 1'b1, ~lk);
    endtask

    initial begin
        repeat (50000) @(posedge i_sys_clk);
        n_errors++;
        results();
    end
    initial begin
        repeat (20) @(posedge i_sys_clk);
        #1;
        i_rst_n = 1'b1;
        t_por();
        t_hwp();
        t_unlock();
        t_range();
        t_both();
        host.wr({10'h002, `FSPU_UNLOCK_CYCLE_ADDR_FIRST_OFS}, `FSPU_CMD_ENTRY);
        host.idle();
        chk("overlay", 16'h1, 16'(o_overlay_active));
        t_otp(1, 1'b0);
        t_otp(256, 1'b0);
        t_otp(4, 1'b1);
        host.wr({10'h1a3, 16'h1234}, `FSPU_CMD_EXIT);
        host.idle();
        chk("overlay", 16'h0, 16'(o_overlay_active));
        results();
    end
endmodule
